// >>> core/gpio_ctrl_pkg.sv
// Constants, register map and carrier types for the GPIO control block.
// Assumes a single core clock domain and an 8-bit register port.
`default_nettype none

package gpio_ctrl_pkg;

  // Pin count and register data width
  localparam int GPIO_PINS = 4;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 16;
  localparam int SEL_W     = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_DIR       = 16'h0030;
  localparam logic [ADDR_W-1:0] ADDR_IN_SEL2   = 16'h0031;
  localparam logic [ADDR_W-1:0] ADDR_IN_SEL1   = 16'h0032;
  localparam logic [ADDR_W-1:0] ADDR_IN_SEL0   = 16'h0033;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL2  = 16'h0034;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL1  = 16'h0035;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL0  = 16'h0036;
  localparam logic [ADDR_W-1:0] ADDR_RESERVED  = 16'h0037;
  localparam logic [ADDR_W-1:0] ADDR_OUT_VAL   = 16'h0038;
  localparam logic [ADDR_W-1:0] ADDR_IN_VAL    = 16'h020C;

  // Values after reset
  localparam logic [GPIO_PINS-1:0] DIR_RESET     = 4'h0;
  localparam logic [SEL_W-1:0]     IN_SEL_RESET  = 3'h1;
  localparam logic [SEL_W-1:0]     OUT_SEL_RESET = 3'h0;
  localparam logic [GPIO_PINS-1:0] OUT_VAL_RESET = 4'h0;

  // Function codes
  localparam logic [SEL_W-1:0] IN_FN_GP      = 3'h0;
  localparam logic [SEL_W-1:0] IN_FN_CTRL    = 3'h1;
  localparam logic [SEL_W-1:0] OUT_FN_SW     = 3'h0;
  localparam logic [SEL_W-1:0] OUT_FN_STATUS = 3'h1;

  // Pins with dedicated input roles
  localparam int PIN_REF_SEL = 2;
  localparam int PIN_OE_SEL1 = 1;
  localparam int PIN_OE_SEL0 = 0;

  // Register request from the serial management engine
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } regReq_t;

  // PLL status flags, one per pin in pin order
  typedef struct packed {
    logic lossOfLock;
    logic losRef0;
    logic losRef1;
    logic holdover;
  } pllStatus_t;

endpackage

`default_nettype wire

// >>> core/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins are quasi-static compared with core_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and control
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             ce,
  // Levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

`default_nettype wire

// >>> core/clock_chip_gpio_control.sv
// GPIO control block: direction, input and output function selects.
// Assumes register requests come from the serial management engine on core_clk.
//
// How it works
// - Each pin has a direction bit, 0 input and 1 output, all resetting to 0.
// - Pins used as plain inputs show their level in the read-only register at 0x020C.
// - Pin 3 as input with select 000 mirrors into bit 3; no other code acts on pin 3.
// - Pin 2 as input with select 001 drives manual reference select, with 000 it mirrors into bit 2.
// - Pin 1 as input with select 001 drives output enable select bit 1, with 000 it mirrors into bit 1.
// - An input function select acts only while its pin is an input.
// - All input function selects reset to 001.
// - Input selects sit as bit planes at 0x31..0x33 and direction at 0x30, pin n in bit n.
// - Output selects sit as bit planes at 0x34..0x36, output values at 0x38, 0x37 reserved.
// - An output pin with select 000 drives its output value bit.
// - Pin 0 as output with select 001 drives the holdover flag.
// - Pin 3 as output with select 001 drives the loss-of-lock flag.
// - Pin 0 as input with select 001 drives output enable select bit 0.
`timescale 1ns/1ps
`default_nettype none

module clock_chip_gpio_control #(
  parameter int NUM_PINS = gpio_ctrl_pkg::GPIO_PINS
) (
  // Clock, reset, enable
  input  wire logic                              core_clk,
  input  wire logic                              srst,
  input  wire logic                              ce,
  // Register port
  input  wire gpio_ctrl_pkg::regReq_t            regReq,
  output logic [gpio_ctrl_pkg::DATA_W-1:0]       regRdData,
  output logic                                   regRdValid,
  // PLL status
  input  wire gpio_ctrl_pkg::pllStatus_t         pllStatus,
  // Pins
  input  wire logic [NUM_PINS-1:0]               gpioIn,
  output logic      [NUM_PINS-1:0]               gpioOut,
  output logic      [NUM_PINS-1:0]               gpioOe,
  // Control functions
  output logic                                   manualRefSelect,
  output logic      [1:0]                        outputEnableSelect
);

  localparam int SW = gpio_ctrl_pkg::SEL_W;

  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] inPlane_q [SW];
  logic [NUM_PINS-1:0] outPlane_q [SW];
  logic [NUM_PINS-1:0] outVal_q;
  logic [NUM_PINS-1:0] inPinValues_q;
  logic [NUM_PINS-1:0] inPinValues_d;
  logic [NUM_PINS-1:0] pinOut_d;
  logic [NUM_PINS-1:0] pinLvl;
  logic [NUM_PINS-1:0] statusVec;
  logic [SW-1:0]       inSel  [NUM_PINS];
  logic [SW-1:0]       outSel [NUM_PINS];
  logic                manualRef_d;
  logic [1:0]          oeSel_d;
  logic [gpio_ctrl_pkg::DATA_W-1:0] rdData_d;
  logic                wrHit;

  assign wrHit     = ce && regReq.wr;
  assign statusVec = pllStatus;

  // Pin synchroniser
  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pinSync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .d        (gpioIn),
    .q        (pinLvl)
  );

  // Direction register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dir_q <= gpio_ctrl_pkg::DIR_RESET;
    end else if (wrHit && regReq.addr == gpio_ctrl_pkg::ADDR_DIR) begin
      dir_q <= regReq.wdata[NUM_PINS-1:0];
    end
  end

  // Select bit planes
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < SW; b++) begin
      if (srst) begin
        inPlane_q[b]  <= {NUM_PINS{gpio_ctrl_pkg::IN_SEL_RESET[b]}};
        outPlane_q[b] <= {NUM_PINS{gpio_ctrl_pkg::OUT_SEL_RESET[b]}};
      end else if (wrHit) begin
        if (regReq.addr == gpio_ctrl_pkg::ADDR_IN_SEL0 - 16'(b)) begin
          inPlane_q[b] <= regReq.wdata[NUM_PINS-1:0];
        end
        if (regReq.addr == gpio_ctrl_pkg::ADDR_OUT_SEL0 - 16'(b)) begin
          outPlane_q[b] <= regReq.wdata[NUM_PINS-1:0];
        end
      end
    end
  end

  // Output value register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      outVal_q <= gpio_ctrl_pkg::OUT_VAL_RESET;
    end else if (wrHit && regReq.addr == gpio_ctrl_pkg::ADDR_OUT_VAL) begin
      outVal_q <= regReq.wdata[NUM_PINS-1:0];
    end
  end

  // Per-pin function decode
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
    assign inSel[n]  = {inPlane_q[2][n], inPlane_q[1][n], inPlane_q[0][n]};
    assign outSel[n] = {outPlane_q[2][n], outPlane_q[1][n], outPlane_q[0][n]};

    // Mirror only plain inputs
    assign inPinValues_d[n] = !dir_q[n] && inSel[n] == gpio_ctrl_pkg::IN_FN_GP
                              ? pinLvl[n] : 1'b0;

    // Reserved codes drive low
    always_comb begin
      case (outSel[n])
        gpio_ctrl_pkg::OUT_FN_SW:     pinOut_d[n] = outVal_q[n];
        gpio_ctrl_pkg::OUT_FN_STATUS: pinOut_d[n] = statusVec[n];
        default:                      pinOut_d[n] = 1'b0;
      endcase
    end
  end

  // Dedicated control roles, inactive outside input mode
  assign manualRef_d = !dir_q[gpio_ctrl_pkg::PIN_REF_SEL]
                       && inSel[gpio_ctrl_pkg::PIN_REF_SEL] == gpio_ctrl_pkg::IN_FN_CTRL
                       && pinLvl[gpio_ctrl_pkg::PIN_REF_SEL];
  assign oeSel_d[1]  = !dir_q[gpio_ctrl_pkg::PIN_OE_SEL1]
                       && inSel[gpio_ctrl_pkg::PIN_OE_SEL1] == gpio_ctrl_pkg::IN_FN_CTRL
                       && pinLvl[gpio_ctrl_pkg::PIN_OE_SEL1];
  assign oeSel_d[0]  = !dir_q[gpio_ctrl_pkg::PIN_OE_SEL0]
                       && inSel[gpio_ctrl_pkg::PIN_OE_SEL0] == gpio_ctrl_pkg::IN_FN_CTRL
                       && pinLvl[gpio_ctrl_pkg::PIN_OE_SEL0];

  // Registered pin and control outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gpioOut            <= '0;
      gpioOe             <= '0;
      inPinValues_q      <= '0;
      manualRefSelect    <= 1'b0;
      outputEnableSelect <= 2'h0;
    end else if (ce) begin
      gpioOut            <= pinOut_d & dir_q;
      gpioOe             <= dir_q;
      inPinValues_q      <= inPinValues_d;
      manualRefSelect    <= manualRef_d;
      outputEnableSelect <= oeSel_d;
    end
  end

  // Read mux, reserved bits and unmapped addresses read zero
  always_comb begin
    rdData_d = '0;
    case (regReq.addr)
      gpio_ctrl_pkg::ADDR_DIR:      rdData_d[NUM_PINS-1:0] = dir_q;
      gpio_ctrl_pkg::ADDR_IN_SEL2:  rdData_d[NUM_PINS-1:0] = inPlane_q[2];
      gpio_ctrl_pkg::ADDR_IN_SEL1:  rdData_d[NUM_PINS-1:0] = inPlane_q[1];
      gpio_ctrl_pkg::ADDR_IN_SEL0:  rdData_d[NUM_PINS-1:0] = inPlane_q[0];
      gpio_ctrl_pkg::ADDR_OUT_SEL2: rdData_d[NUM_PINS-1:0] = outPlane_q[2];
      gpio_ctrl_pkg::ADDR_OUT_SEL1: rdData_d[NUM_PINS-1:0] = outPlane_q[1];
      gpio_ctrl_pkg::ADDR_OUT_SEL0: rdData_d[NUM_PINS-1:0] = outPlane_q[0];
      gpio_ctrl_pkg::ADDR_OUT_VAL:  rdData_d[NUM_PINS-1:0] = outVal_q;
      gpio_ctrl_pkg::ADDR_IN_VAL:   rdData_d[NUM_PINS-1:0] = inPinValues_q;
      default:                      rdData_d = '0;
    endcase
  end

  // Read answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      regRdData  <= '0;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regReq.rd;
      if (regReq.rd) begin
        regRdData <= rdData_d;
      end
    end else begin
      regRdValid <= 1'b0;
    end
  end

  // Checks
  property p_resetValues;
    @(posedge core_clk) disable iff (srst)
      $past(srst) |-> dir_q == gpio_ctrl_pkg::DIR_RESET && gpioOe == '0
                      && inPlane_q[0] == '1 && inPlane_q[1] == '0 && inPlane_q[2] == '0;
  endproperty
  a_resetValues: assert property (p_resetValues) else $error("Reset values wrong");

  property p_selReset;
    @(posedge core_clk) disable iff (srst)
      $past(srst) |-> inSel[1] == 3'h1 && inSel[2] == 3'h1 && inSel[3] == 3'h1;
  endproperty
  a_selReset: assert property (p_selReset) else $error("Input selects not 001 after reset");

  property p_mirrorPin3;
    @(posedge core_clk) disable iff (srst)
      ce && !dir_q[3] && inSel[3] == 3'h0 |=> inPinValues_q[3] == $past(pinLvl[3]);
  endproperty
  a_mirrorPin3: assert property (p_mirrorPin3) else $error("Pin 3 level not mirrored");

  property p_pin3NoCtrl;
    @(posedge core_clk) disable iff (srst)
      ce && inSel[3] != 3'h0 |=> inPinValues_q[3] == 1'b0;
  endproperty
  a_pin3NoCtrl: assert property (p_pin3NoCtrl) else $error("Pin 3 mirrored under other code");

  property p_refSelect;
    @(posedge core_clk) disable iff (srst)
      ce && !dir_q[2] && inSel[2] == 3'h1 |=> manualRefSelect == $past(pinLvl[2]) && !inPinValues_q[2];
  endproperty
  a_refSelect: assert property (p_refSelect) else $error("Reference select not following pin 2");

  property p_oeSel1;
    @(posedge core_clk) disable iff (srst)
      ce && !dir_q[1] && inSel[1] == 3'h1 |=> outputEnableSelect[1] == $past(pinLvl[1]);
  endproperty
  a_oeSel1: assert property (p_oeSel1) else $error("Enable select bit 1 not following pin 1");

  property p_oeSel0;
    @(posedge core_clk) disable iff (srst)
      ce && !dir_q[0] && inSel[0] == 3'h1 |=> outputEnableSelect[0] == $past(pinLvl[0]);
  endproperty
  a_oeSel0: assert property (p_oeSel0) else $error("Enable select bit 0 not following pin 0");

  property p_outModeIgnoresIn;
    @(posedge core_clk) disable iff (srst)
      ce && dir_q[2] |=> !manualRefSelect && gpioOe[2] && !inPinValues_q[2];
  endproperty
  a_outModeIgnoresIn: assert property (p_outModeIgnoresIn) else $error("Input role active in output mode");

  property p_holdover;
    @(posedge core_clk) disable iff (srst)
      ce && dir_q[0] && outSel[0] == 3'h1 |=> gpioOut[0] == $past(pllStatus.holdover);
  endproperty
  a_holdover: assert property (p_holdover) else $error("Pin 0 not showing holdover");

  property p_lossOfLock;
    @(posedge core_clk) disable iff (srst)
      ce && dir_q[3] && outSel[3] == 3'h1 |=> gpioOut[3] == $past(pllStatus.lossOfLock);
  endproperty
  a_lossOfLock: assert property (p_lossOfLock) else $error("Pin 3 not showing loss of lock");

  property p_swOut;
    @(posedge core_clk) disable iff (srst)
      ce && dir_q[1] && outSel[1] == 3'h0 |=> gpioOut[1] == $past(outVal_q[1]) && gpioOe[1];
  endproperty
  a_swOut: assert property (p_swOut) else $error("Pin 1 not driving software value");

  property p_planeWrite;
    @(posedge core_clk) disable iff (srst)
      ce && regReq.wr && regReq.addr == 16'h0031 |=> inPlane_q[2] == $past(regReq.wdata[3:0]);
  endproperty
  a_planeWrite: assert property (p_planeWrite) else $error("Plane 2 write lost");

  property p_outPlaneRead;
    @(posedge core_clk) disable iff (srst)
      ce && regReq.rd && !regReq.wr && regReq.addr == 16'h0036
        |=> regRdValid && regRdData == {4'h0, $past(outPlane_q[0])};
  endproperty
  a_outPlaneRead: assert property (p_outPlaneRead) else $error("Plane 0 readback wrong");

  property p_syncDepth;
    @(posedge core_clk) disable iff (srst)
      ce ##1 ce |=> pinLvl == $past(gpioIn, 2);
  endproperty
  a_syncDepth: assert property (p_syncDepth) else $error("Synchroniser depth wrong");

  // Enable low freezes pins, controls and registers, and drops the read valid
  property p_ceFreeze;
    @(posedge core_clk) disable iff (srst)
      !ce |=> $stable(dir_q) && $stable(gpioOut) && $stable(manualRefSelect) && !regRdValid;
  endproperty
  a_ceFreeze: assert property (p_ceFreeze) else $error("State moved while enable low");

  // Reserved slot reads zero
  property p_reservedRead;
    @(posedge core_clk) disable iff (srst)
      ce && regReq.rd && regReq.addr == gpio_ctrl_pkg::ADDR_RESERVED |=> regRdData == 8'h00;
  endproperty
  a_reservedRead: assert property (p_reservedRead) else $error("Reserved slot not reading zero");

  // Reserved output code drives low
  property p_reservedOut;
    @(posedge core_clk) disable iff (srst)
      ce && dir_q[1] && outSel[1] == 3'h2 |=> !gpioOut[1];
  endproperty
  a_reservedOut: assert property (p_reservedOut) else $error("Reserved output code driving pin");

  c_refSelect: cover property (@(posedge core_clk) disable iff (srst) $rose(manualRefSelect));
  c_holdoverOut: cover property (@(posedge core_clk) disable iff (srst) dir_q[0] && outSel[0] == 3'h1 && gpioOut[0]);
  c_plainInput: cover property (@(posedge core_clk) disable iff (srst) inPinValues_q[3]);
  c_readValues: cover property (@(posedge core_clk) disable iff (srst) regRdValid && regRdData != '0);
  c_ceLow: cover property (@(posedge core_clk) disable iff (srst) !ce ##1 !ce);

endmodule

`default_nettype wire

// >>> testbench/gpio_board_model.sv
// Board-side model of the four general-purpose pins.
// Assumes the device output enable and drive value come straight from the block.
`timescale 1ns/1ps
`default_nettype none

module gpio_board_model (
  // Device side
  input  wire logic [3:0] gpioOut,
  input  wire logic [3:0] gpioOe,
  // Board stimulus
  input  wire logic [3:0] boardLevel,
  input  wire logic [3:0] boardEn,
  // Resolved pin level
  output logic      [3:0] pinLevel
);
  // Device wins when it drives, else board, else pull-up
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (gpioOe[i]) begin
        pinLevel[i] = gpioOut[i];
      end else if (boardEn[i]) begin
        pinLevel[i] = boardLevel[i];
      end else begin
        pinLevel[i] = 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> testbench/clock_chip_gpio_control_tb_top.sv
// Self-checking bench for the GPIO control block.
// Assumes one 25 MHz core clock and the board model on the pins.
`timescale 1ns/1ps
`default_nettype none

module clock_chip_gpio_control_tb_top;
  logic                      core_clk;
  logic                      srst;
  logic                      ce;
  gpio_ctrl_pkg::regReq_t    regReq;
  logic [7:0]                regRdData;
  logic                      regRdValid;
  gpio_ctrl_pkg::pllStatus_t pllStatus;
  logic [3:0]                gpioIn;
  logic [3:0]                gpioOut;
  logic [3:0]                gpioOe;
  logic                      manualRefSelect;
  logic [1:0]                outputEnableSelect;
  logic [3:0]                boardLevel;
  logic [3:0]                boardEn;
  int                        num_errors;
  int                        total_checks;
  logic [7:0]                rstVal [9] = '{8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  clock_chip_gpio_control dut_u (
    .core_clk(core_clk), .srst(srst), .ce(ce), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .pllStatus(pllStatus), .gpioIn(gpioIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .manualRefSelect(manualRefSelect), .outputEnableSelect(outputEnableSelect)
  );

  gpio_board_model board_u (
    .gpioOut(gpioOut), .gpioOe(gpioOe), .boardLevel(boardLevel), .boardEn(boardEn), .pinLevel(gpioIn)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Upper nibble always written as zero
  task automatic wrReg(input logic [15:0] a, input logic [3:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: {4'h0, d}};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regReq <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    @(negedge core_clk);
    chk({7'h00, regRdValid}, 8'h01);
    chk(regRdData, e);
  endtask

  task automatic settle(input logic [3:0] pins);
    @(posedge core_clk);
    boardLevel <= pins;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic ctrlChk(input logic [2:0] e);
    chk({5'h00, manualRefSelect, outputEnableSelect}, {5'h00, e});
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    ce = 1'b1;
    regReq = '0;
    pllStatus = '0;
    boardLevel = 4'h0;
    boardEn = 4'hF;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 9; i++) rdChk(16'h0030 + 16'(i), rstVal[i]);
    chk({4'h0, gpioOe}, 8'h00);
    // Power-up control roles on pins 0..2
    settle(4'hF);
    ctrlChk(3'b111);
    rdChk(16'h020C, 8'h00);
    settle(4'hA);
    ctrlChk(3'b010);
    // Plain inputs
    wrReg(16'h0033, 4'h0);
    settle(4'hA);
    rdChk(16'h020C, 8'h0A);
    ctrlChk(3'b000);
    settle(4'h5);
    rdChk(16'h020C, 8'h05);
    // Write and read back every plane
    for (int i = 1; i < 9; i++) begin
      if (i != 7) begin
        wrReg(16'h0030 + 16'(i), 4'(i + 6));
        rdChk(16'h0030 + 16'(i), {4'h0, 4'(i + 6)});
        wrReg(16'h0030 + 16'(i), 4'h0);
      end
    end
    // Reserved slot ignores writes and reads zero
    wrReg(16'h0037, 4'hF);
    rdChk(16'h0037, 8'h00);
    // Software drive in output mode
    wrReg(16'h0030, 4'hF);
    wrReg(16'h0038, 4'h9);
    settle(4'hF);
    chk({gpioOe, gpioOut}, 8'hF9);
    rdChk(16'h020C, 8'h00);
    wrReg(16'h0033, 4'hF);
    settle(4'hF);
    ctrlChk(3'b000);
    // Status flags on output pins
    wrReg(16'h0036, 4'hF);
    @(posedge core_clk);
    pllStatus <= 4'hA;
    settle(4'hF);
    chk({4'h0, gpioOut}, 8'h0A);
    @(posedge core_clk);
    pllStatus <= 4'h5;
    settle(4'hF);
    chk({4'h0, gpioOut}, 8'h05);
    // Mixed directions: pins 0 and 3 out, 1 and 2 in
    wrReg(16'h0030, 4'h9);
    settle(4'hF);
    chk({gpioOe, gpioOut}, 8'h91);
    ctrlChk(3'b110);
    // Enable low freezes the synchronised controls
    @(posedge core_clk);
    ce <= 1'b0;
    settle(4'h0);
    ctrlChk(3'b110);
    chk({7'h00, regRdValid}, 8'h00);
    @(posedge core_clk);
    ce <= 1'b1;
    settle(4'h0);
    ctrlChk(3'b000);
    end_sim();
  end
endmodule

`default_nettype wire
